// *** rtl/port_cfg_pkg.sv ***
// Shared constants, field layouts and carrier types of the GPIO port block.
package port_cfg_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_PORT0_VALUE = 8'h80;
   localparam logic [7:0] OFS_PORT1_VALUE = 8'h90;
   localparam logic [7:0] OFS_PORT2_VALUE = 8'ha0;
   localparam logic [7:0] OFS_PORT3_VALUE = 8'hb0;
   // Direction registers sit one word above each value register.
   localparam logic [7:0] OFS_DIR_STEP = 8'h04;
   localparam logic [7:0] OFS_PORT3_CFG = 8'hc0;
   localparam logic [7:0] PORT_VALUE_RESET = 8'hff;
   localparam logic [7:0] PORT_DIR_RESET = 8'h00;

   // ****************************************************************
   // Pin configuration word layout
   // ****************************************************************
   localparam int CFG_CODE_MSB = 7;
   localparam int CFG_CODE_LSB = 5;
   localparam int CFG_RDPTR_BIT = 4;
   localparam int CFG_DIR_BIT = 3;
   localparam int CFG_IDX_MSB = 2;
   // Direction selector value that picks the output configuration.
   localparam logic DIR_SEL_OUTPUT = 1'b0;

   // ****************************************************************
   // Mode codes and their values after reset
   // ****************************************************************
   localparam logic [2:0] OUT_NORMAL = 3'h0;
   localparam logic [2:0] OUT_HIGH = 3'h3;
   localparam logic [1:0] IN_NO_PULL = 2'h0;
   localparam logic [1:0] IN_PULL_DOWN = 2'h1;
   localparam logic [1:0] IN_PULL_UP = 2'h2;
   localparam logic [1:0] IN_OFF = 2'h3;
   localparam logic [2:0] OUT_MODE_RESET = 3'h0;
   localparam logic [1:0] IN_MODE_RESET = 2'h0;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic en;
      logic sel_input;
      logic [2:0] index;
      logic [2:0] code;
   } mode_write_type;

   typedef enum logic [0:0] {
      APB_WAIT = 1'b0,
      APB_DONE = 1'b1
   } apb_state_type;

endpackage

// *** rtl/pin_mode_store.sv ***
// Per-pin input and output mode storage with a registered read port.
`timescale 1ns/1ps
module pin_mode_store #(
   parameter int NUM_PINS = 8
) (
   // Clock and synchronised reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Mode update and read pointer.
   input wire port_cfg_pkg::mode_write_type i_wr,
   input wire logic [2:0] i_rd_index,
   input wire logic i_rd_input,
   // Registered read data and decoded pad controls.
   output logic [2:0] o_rd_code,
   output logic [7:0] o_high_drive,
   output logic [7:0] o_input_enable,
   output logic [7:0] o_pull_up,
   output logic [7:0] o_pull_down
);

   // Pin counts beyond the eight stored words cannot be served.
   if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
      $error("NUM_PINS must lie between 1 and 8");
   end

   logic [2:0] out_mode_reg [8];
   logic [1:0] in_mode_reg [8];

   // Stored modes; pins beyond the package are never touched.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 8; i++) begin
            out_mode_reg[i] <= port_cfg_pkg::OUT_MODE_RESET;
            in_mode_reg[i] <= port_cfg_pkg::IN_MODE_RESET;
         end
      end else if (i_wr.en && (int'(i_wr.index) < NUM_PINS)) begin // [R10]
         if (i_wr.sel_input) begin
            in_mode_reg[i_wr.index] <= i_wr.code[1:0]; // [R4]
         end else begin
            out_mode_reg[i_wr.index] <= i_wr.code; // [R4]
         end
      end
   end

   // Read data and pad controls come out of flip-flops.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_code <= 3'h0;
         o_high_drive <= 8'h00;
         o_input_enable <= 8'hff;
         o_pull_up <= 8'h00;
         o_pull_down <= 8'h00;
      end else begin
         if (int'(i_rd_index) >= NUM_PINS) begin
            o_rd_code <= 3'h0;
         end else if (i_rd_input) begin
            o_rd_code <= {1'b0, in_mode_reg[i_rd_index]}; // [R8]
         end else begin
            o_rd_code <= out_mode_reg[i_rd_index]; // [R8]
         end
         for (int i = 0; i < 8; i++) begin
            o_high_drive[i] <=
               out_mode_reg[i] == port_cfg_pkg::OUT_HIGH; // [R6]
            o_input_enable[i] <=
               in_mode_reg[i] != port_cfg_pkg::IN_OFF; // [R7]
            o_pull_up[i] <= in_mode_reg[i] == port_cfg_pkg::IN_PULL_UP;
            o_pull_down[i] <= in_mode_reg[i] == port_cfg_pkg::IN_PULL_DOWN;
         end
      end
   end

endmodule

// *** rtl/port_gpio.sv ***
// APB register block for four GPIO ports and indirect port 3 pin modes.
//
// How it works
// (R1) Direction selector bit zero chooses output configuration, one chooses input.
// (R2) Read-pointer write stores pin index and direction selector for later reads.
// (R3) Read-pointer write ignores the mode field and changes no pin mode.
// (R4) Without read-pointer flag, the addressed pin's chosen mode takes the code.
// (R5) Output mode code sits in bits 7:5; only 000 and 011 accepted.
// (R6) Output code 000 gives normal drive, 011 gives high drive.
// (R7) Input code 11 turns the input buffer off; others keep it on.
// (R8) Configuration read returns the mode of the pointed pin and direction.
// (R9) Four eight-bit read/write port value registers, reset to all ones.
// (R10) Mode writes naming a pin beyond the package change nothing at all; pointer writes still store the index.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module port_gpio #(
   parameter int NUM_PINS = 8
) (
   // Clock and asynchronous active-low reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // APB slave.
   input wire port_cfg_pkg::apb_req_type i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Port pins, three signals per two-way pin.
   input wire logic [3:0][7:0] i_port_pins,
   output logic [3:0][7:0] o_port_out,
   output logic [3:0][7:0] o_port_oe,
   // Port 3 pad controls.
   output logic [7:0] o_port3_high_drive,
   output logic [7:0] o_port3_input_enable,
   output logic [7:0] o_port3_pull_up,
   output logic [7:0] o_port3_pull_down
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
      $error("NUM_PINS must lie between 1 and 8");
   end

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_n;

   // Two flops so the release never lands close to a clock edge.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   // Returns the port number whose value or direction word is addressed.
   function automatic logic [1:0] port_of(input logic [7:0] addr);
      port_of = addr[5:4];
   endfunction

   // Only the two documented output codes may reach the pad.
   function automatic logic out_code_legal(input logic [2:0] code);
      out_code_legal = (code == port_cfg_pkg::OUT_NORMAL) ||
                       (code == port_cfg_pkg::OUT_HIGH);
   endfunction

   // ****************************************************************
   // APB handshake
   // ****************************************************************
   port_cfg_pkg::apb_state_type state_reg;
   port_cfg_pkg::apb_state_type state_next;
   logic access;
   logic done;
   logic wr_done;

   // The answer comes one cycle into the access phase, so every transfer
   // takes exactly three cycles; this keeps read data fully registered.
   assign access = i_apb.psel && i_apb.penable;
   assign done = access && (state_reg == port_cfg_pkg::APB_DONE);
   assign wr_done = done && i_apb.pwrite;

   always_comb begin
      case (state_reg)
         port_cfg_pkg::APB_WAIT: begin
            state_next = access ? port_cfg_pkg::APB_DONE :
                                  port_cfg_pkg::APB_WAIT;
         end
         port_cfg_pkg::APB_DONE: begin
            state_next = port_cfg_pkg::APB_WAIT;
         end
         default: begin
            state_next = port_cfg_pkg::APB_WAIT;
         end
      endcase
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   logic [1:0] port_sel;
   logic value_hit;
   logic dir_hit;
   logic cfg_hit;
   logic any_hit;

   assign port_sel = port_of(i_apb.paddr);
   assign value_hit = (i_apb.paddr[7:6] == 2'h2) &&
                      (i_apb.paddr[3:0] == 4'h0);
   assign dir_hit = (i_apb.paddr[7:6] == 2'h2) &&
                    (i_apb.paddr[3:0] == port_cfg_pkg::OFS_DIR_STEP[3:0]);
   assign cfg_hit = i_apb.paddr == port_cfg_pkg::OFS_PORT3_CFG;
   assign any_hit = value_hit || dir_hit || cfg_hit;

   // ****************************************************************
   // Port value and direction registers
   // ****************************************************************
   logic [3:0][7:0] value_reg;
   logic [3:0][7:0] dir_reg;

   // A write lands only at the edge where the transfer completes.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < 4; p++) begin
            value_reg[p] <= port_cfg_pkg::PORT_VALUE_RESET; // [R9]
            dir_reg[p] <= port_cfg_pkg::PORT_DIR_RESET;
         end
      end else if (wr_done && value_hit) begin
         value_reg[port_sel] <= i_apb.pwdata[7:0]; // [R9]
      end else if (wr_done && dir_hit) begin
         dir_reg[port_sel] <= i_apb.pwdata[7:0];
      end
   end

   // ****************************************************************
   // Pin configuration write path
   // ****************************************************************
   logic [2:0] cfg_code;
   logic cfg_rdptr;
   logic cfg_sel_input;
   logic [2:0] cfg_index;
   logic cfg_wr;
   logic code_ok;
   logic index_ok;
   port_cfg_pkg::mode_write_type mode_wr;

   assign cfg_code = i_apb.pwdata[port_cfg_pkg::CFG_CODE_MSB:
                                  port_cfg_pkg::CFG_CODE_LSB]; // [R5]
   assign cfg_rdptr = i_apb.pwdata[port_cfg_pkg::CFG_RDPTR_BIT];
   assign cfg_sel_input = i_apb.pwdata[port_cfg_pkg::CFG_DIR_BIT] !=
                          port_cfg_pkg::DIR_SEL_OUTPUT; // [R1]
   assign cfg_index = i_apb.pwdata[port_cfg_pkg::CFG_IDX_MSB:0];
   assign cfg_wr = wr_done && cfg_hit;
   // Illegal output codes are dropped rather than left to reach the pad.
   assign code_ok = cfg_sel_input || out_code_legal(cfg_code); // [R5]
   assign index_ok = int'(cfg_index) < NUM_PINS; // [R10]

   // Pointer writes never update a mode.
   assign mode_wr.en = cfg_wr && !cfg_rdptr && code_ok && index_ok; // [R3]
   assign mode_wr.sel_input = cfg_sel_input; // [R1]
   assign mode_wr.index = cfg_index;
   assign mode_wr.code = cfg_code; // [R4]

   // ****************************************************************
   // Read pointer
   // ****************************************************************
   logic [2:0] ptr_index_reg;
   logic ptr_input_reg;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_index_reg <= 3'h0;
         ptr_input_reg <= 1'b0;
      end else if (cfg_wr && cfg_rdptr) begin
         ptr_index_reg <= cfg_index; // [R2]
         ptr_input_reg <= cfg_sel_input; // [R2]
      end
   end

   // ****************************************************************
   // Mode storage
   // ****************************************************************
   logic [2:0] rd_code;
   logic [7:0] high_drive;
   logic [7:0] input_enable;
   logic [7:0] pull_up;
   logic [7:0] pull_down;

   pin_mode_store #(
      .NUM_PINS(NUM_PINS)
   ) u_store (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_wr(mode_wr),
      .i_rd_index(ptr_index_reg),
      .i_rd_input(ptr_input_reg),
      .o_rd_code(rd_code),
      .o_high_drive(high_drive),
      .o_input_enable(input_enable),
      .o_pull_up(pull_up),
      .o_pull_down(pull_down)
   );

   assign o_port3_high_drive = high_drive;
   assign o_port3_input_enable = input_enable;
   assign o_port3_pull_up = pull_up;
   assign o_port3_pull_down = pull_down;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] pin_view;
   logic [7:0] port_view;
   logic [7:0] cfg_view;
   logic [31:0] rdata_next;

   // Pins with the input buffer off read as zero on port 3.
   assign pin_view = (port_sel == 2'h3) ?
                     (i_port_pins[port_sel] & input_enable) :
                     i_port_pins[port_sel];
   // Driven bits read back the latch, sensed bits read the pin.
   assign port_view = (value_reg[port_sel] & dir_reg[port_sel]) |
                      (pin_view & ~dir_reg[port_sel]);
   assign cfg_view = {rd_code, 1'b0, ptr_input_reg, ptr_index_reg}; // [R8]
   assign rdata_next = value_hit ? {24'h0000_00, port_view} :
                       dir_hit ? {24'h0000_00, dir_reg[port_sel]} :
                       cfg_hit ? {24'h0000_00, cfg_view} :
                       32'h0000_0000;

   // Answer flops; data and error only change with the answer.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= port_cfg_pkg::APB_WAIT;
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         state_reg <= state_next;
         o_pready <= state_next == port_cfg_pkg::APB_DONE;
         if (access && state_reg == port_cfg_pkg::APB_WAIT) begin
            o_prdata <= i_apb.pwrite ? 32'h0000_0000 : rdata_next;
            o_pslverr <= !any_hit;
         end
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_port_out <= {4{port_cfg_pkg::PORT_VALUE_RESET}};
         o_port_oe <= {4{port_cfg_pkg::PORT_DIR_RESET}};
      end else begin
         o_port_out <= value_reg; // [R9]
         o_port_oe <= dir_reg;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   property p_sel_dir;
      mode_wr.en |-> (mode_wr.sel_input == i_apb.pwdata[3]);
   endproperty
   a_sel_dir: assert property (p_sel_dir) // [R1]
      else $error("mode write took the wrong direction");

   property p_ptr_store;
      (cfg_wr && cfg_rdptr) |=>
         (ptr_index_reg == $past(i_apb.pwdata[2:0])) &&
         (ptr_input_reg == $past(i_apb.pwdata[3]));
   endproperty
   a_ptr_store: assert property (p_ptr_store) // [R2]
      else $error("read pointer not stored");

   property p_ptr_no_mode;
      (cfg_wr && cfg_rdptr) |-> !mode_wr.en;
   endproperty
   a_ptr_no_mode: assert property (p_ptr_no_mode) // [R3]
      else $error("pointer write changed a pin mode");

   property p_illegal_out;
      (cfg_wr && !cfg_sel_input && !out_code_legal(cfg_code)) |->
         !mode_wr.en;
   endproperty
   a_illegal_out: assert property (p_illegal_out) // [R5]
      else $error("illegal output code accepted");

   property p_high_drive;
      (mode_wr.en && !mode_wr.sel_input && mode_wr.code == 3'h3) |->
         ##2 o_port3_high_drive[$past(mode_wr.index, 2)];
   endproperty
   a_high_drive: assert property (p_high_drive) // [R6]
      else $error("high drive not applied");

   property p_in_off;
      (mode_wr.en && mode_wr.sel_input && mode_wr.code[1:0] == 2'h3) |->
         ##2 !o_port3_input_enable[$past(mode_wr.index, 2)];
   endproperty
   a_in_off: assert property (p_in_off) // [R7]
      else $error("input buffer not switched off");

   property p_value_wr;
      (wr_done && value_hit) |=> ##1
         (o_port_out[$past(port_sel, 2)] == $past(i_apb.pwdata[7:0], 2));
   endproperty
   a_value_wr: assert property (p_value_wr) // [R9]
      else $error("port value write lost");

   property p_index_range;
      mode_wr.en |-> (int'(mode_wr.index) < NUM_PINS);
   endproperty
   a_index_range: assert property (p_index_range) // [R10]
      else $error("mode write to absent pin");

   property p_cfg_read;
      (access && !i_apb.pwrite && cfg_hit &&
       state_reg == port_cfg_pkg::APB_WAIT) |=>
         o_pready && (o_prdata[4:0] ==
                      {1'b0, ptr_input_reg, ptr_index_reg});
   endproperty
   a_cfg_read: assert property (p_cfg_read) // [R8]
      else $error("configuration read pointer fields wrong");

   // Normal drive must clear a high drive left from an earlier write.
   property p_normal_drive;
      (mode_wr.en && !mode_wr.sel_input &&
       mode_wr.code == port_cfg_pkg::OUT_NORMAL) |->
         ##2 !o_port3_high_drive[$past(mode_wr.index, 2)];
   endproperty
   a_normal_drive: assert property (p_normal_drive) // [R6]
      else $error("normal drive not applied");

   // A pull-up code keeps the input buffer on and picks only the pull-up.
   property p_pull_up;
      (mode_wr.en && mode_wr.sel_input &&
       mode_wr.code[1:0] == port_cfg_pkg::IN_PULL_UP) |->
         ##2 (o_port3_input_enable[$past(mode_wr.index, 2)] &&
              o_port3_pull_up[$past(mode_wr.index, 2)] &&
              !o_port3_pull_down[$past(mode_wr.index, 2)]);
   endproperty
   a_pull_up: assert property (p_pull_up) // [R7]
      else $error("pull-up mode not applied");

   // Pad controls must not move after a pointer write has landed.
   property p_ptr_pads_kept;
      (cfg_wr && cfg_rdptr) |=> ##1
         ($stable(o_port3_high_drive) && $stable(o_port3_input_enable) &&
          $stable(o_port3_pull_up) && $stable(o_port3_pull_down));
   endproperty
   a_ptr_pads_kept: assert property (p_ptr_pads_kept) // [R3]
      else $error("pointer write moved a pad control");

endmodule

// *** tb/pin_partner.sv ***
// Behavioural board side of the four ports: drivers, pulls, loose lines.
`timescale 1ns/1ps
module pin_partner (
   // Clock for the loose-line pattern.
   input wire logic i_clk,
   // Pad controls from the device.
   input wire logic [3:0][7:0] i_out,
   input wire logic [3:0][7:0] i_oe,
   input wire logic [7:0] i_pull_up,
   input wire logic [7:0] i_pull_down,
   // Board driver.
   input wire logic i_ext_en,
   input wire logic [3:0][7:0] i_ext,
   // Resolved pin levels.
   output logic [3:0][7:0] o_pins
);
   logic [7:0] float_reg = 8'h55;

   // A loose line keeps changing, so no stale level can pass for data.
   always_ff @(posedge i_clk) begin
      float_reg <= ~float_reg;
   end

   // Device drive first, then the board, then port 3 pulls.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (i_oe[p][b])
               o_pins[p][b] = i_out[p][b];
            else if (i_ext_en)
               o_pins[p][b] = i_ext[p][b];
            else if (p == 3 && i_pull_up[b])
               o_pins[p][b] = 1'b1;
            else if (p == 3 && i_pull_down[b])
               o_pins[p][b] = 1'b0;
            else
               o_pins[p][b] = float_reg[b];
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the GPIO port block against an integer model.
`timescale 1ns/1ps
module tb_top;
   // Fewer pins than the port holds, so absent pins get exercised.
   localparam int NP = 6;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   port_cfg_pkg::apb_req_type apb = '0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic [3:0][7:0] pins;
   logic [3:0][7:0] pout;
   logic [3:0][7:0] poe;
   logic [3:0][7:0] ext = '0;
   logic [7:0] hd;
   logic [7:0] ie;
   logic [7:0] pu;
   logic [7:0] pd;
   int mismatches = 0;
   int checked = 0;
   logic [31:0] seed = 32'h0000_0046;
   int val[4];
   int dir[4];
   int outm[8];
   int inm[8];
   int pidx;
   int pdir;

   // ****************************************************************
   // Design, board and clock
   // ****************************************************************
   port_gpio #(.NUM_PINS(NP)) u_port_gpio (.i_clk(clk), .i_resetn(resetn),
      .i_apb(apb), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_port_pins(pins), .o_port_out(pout),
      .o_port_oe(poe), .o_port3_high_drive(hd), .o_port3_input_enable(ie),
      .o_port3_pull_up(pu), .o_port3_pull_down(pd));
   pin_partner u_pin_partner (.i_clk(clk), .i_out(pout), .i_oe(poe),
      .i_pull_up(pu), .i_pull_down(pd), .i_ext_en(1'b1), .i_ext(ext),
      .o_pins(pins));

   // Free-running 250 MHz clock.
   initial begin
      forever #2 clk = ~clk;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] x,
                         input logic ge, input logic xe);
      checked++;
      if (g !== x || ge !== xe) begin
         mismatches++;
         $display("Error %0t read %h err %b want %h %b", $time, g, ge, x, xe);
      end
   endtask

   task automatic cmp_pad(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("Error %0t pads %h want %h", $time, g, x);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      int n;
      n = 0;
      @(posedge clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         $display("Error %0t no answer from the slave", $time);
         report_and_stop();
      end
   endtask

   // Reference model: applies a transfer and gives the expected answer.
   task automatic mdl(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] x,
                      output logic e);
      int p;
      logic [7:0] lv;
      logic [2:0] i;
      p = a[5:4];
      x = '0;
      e = 1'b0;
      i = d[2:0];
      if (a == 8'hc0) begin
         if (w && d[4]) begin
            pidx = i;
            pdir = d[3];
         end else if (w && i < NP && d[3])
            inm[i] = d[6:5];
         else if (w && i < NP && (d[7:5] == 0 || d[7:5] == 3))
            outm[i] = d[7:5];
         lv = pdir ? inm[pidx] : outm[pidx];
         if (!w) x = {lv[2:0], 1'b0, pdir[0], pidx[2:0]};
      end else if (a[7:6] == 2'b10 && a[3:0] == 4'h0) begin
         if (w) val[p] = d[7:0];
         lv = ext[p];
         for (int b = 0; b < 8; b++) begin
            if (p == 3 && inm[b] == 3) lv[b] = 1'b0;
         end
         if (!w) x = (val[p] & dir[p]) | (lv & ~dir[p]);
      end else if (a[7:6] == 2'b10 && a[3:0] == 4'h4) begin
         if (w) dir[p] = d[7:0];
         if (!w) x = dir[p];
      end else
         e = 1'b1;
   endtask

   task automatic op(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      logic [31:0] r;
      logic [31:0] x;
      logic e;
      logic xe;
      xfer(w, a, d, r, e);
      mdl(w, a, d, x, xe);
      cmp_rd(r, x, e, xe);
   endtask

   // Pad controls lag the register by one edge; three are allowed.
   task automatic pads();
      logic [31:0] x;
      repeat (3) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
         x[24 + b] = outm[b] == 3;
         x[16 + b] = inm[b] != 3;
         x[8 + b] = inm[b] == 2;
         x[b] = inm[b] == 1;
      end
      cmp_pad({hd, ie, pu, pd}, x);
      for (int p = 0; p < 4; p++) begin
         cmp_pad({16'h0000, pout[p], poe[p]}, (val[p] << 8) | dir[p]);
      end
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] r;
      logic [31:0] k;
      for (int p = 0; p < 4; p++) begin
         val[p] = 8'hff;
         dir[p] = 0;
      end
      for (int b = 0; b < 8; b++) begin
         outm[b] = 0;
         inm[b] = 0;
      end
      pidx = 0;
      pdir = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      pads();
      // Random port traffic with the board lines changing underneath.
      repeat (40) begin
         ext <= rnd();
         repeat (4) @(posedge clk);
         r = rnd();
         op(r[3], {2'b10, r[1:0], 1'b0, r[2], 2'b00}, rnd());
      end
      pads();
      // Every code in both directions, then a pointer write with junk.
      for (int c = 0; c < 16; c++) begin
         k = c * 3;
         op(1'b1, 8'hc0, {24'h0, k[2:0], 1'b0, k[3], k[2:0]});
         op(1'b1, 8'hc0, {24'h0, 3'h7, 1'b1, k[3], k[2:0]});
         op(1'b0, 8'hc0, 32'h0000_0000);
         pads();
      end
      // Random configuration words and pointers.
      repeat (40) begin
         op(1'b1, 8'hc0, rnd());
         op(1'b1, 8'hc0, rnd() | 32'h0000_0010);
         op(1'b0, 8'hc0, 32'h0000_0000);
      end
      pads();
      // Port 3 as inputs: pins with the buffer off read low.
      op(1'b1, 8'hb4, 32'h0000_0000);
      op(1'b0, 8'hb0, 32'h0000_0000);
      // Unmapped places answer with an error and change nothing.
      op(1'b1, 8'h10, 32'h0000_00aa);
      op(1'b0, 8'h10, 32'h0000_0000);
      op(1'b0, 8'hc4, 32'h0000_0000);
      pads();
      report_and_stop();
   end
endmodule
